// file: hw/alu_ops_pkg.sv
`default_nettype none
package alu_ops_pkg;
	localparam int DATA_W = 8;
	localparam int REG_AW = 6;
	localparam int ROM_W = 14;
	localparam int ROM_AW = 11;
	localparam int PTR_BITS = 3;
	localparam int TDH_W = 6;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] T0MODE_RST = 8'h00;
	localparam logic [7:0] TPH_RST = 8'h00;
	localparam logic [5:0] TDH_RST = 6'h00;
	// block-local operation codes, one per instruction
	localparam logic [2:0] OP_NOP = 3'h0;
	localparam logic [2:0] OP_SUB_IMM = 3'h1;
	localparam logic [2:0] OP_TABLE = 3'h2;
	localparam logic [2:0] OP_T0_LOAD = 3'h3;
	localparam logic [2:0] OP_T0_READ = 3'h4;
	localparam logic [2:0] OP_XOR_REG = 3'h5;
	localparam logic [2:0] OP_XOR_IMM = 3'h6;
	localparam logic [2:0] OP_TPH_LOAD = 3'h7;
	typedef enum logic [1:0] {
		ST_EXEC  = 2'b01,
		ST_TABLE = 2'b10
	} exec_state_e;
endpackage
`default_nettype wire

// file: hw/sub_flags.sv
`default_nettype none
module sub_flags
	import alu_ops_pkg::*;
(
	input  wire logic [7:0] minuend_i,
	input  wire logic [7:0] subtrahend_i,
	output logic      [7:0] diff_o,
	output logic            zero_o,
	output logic            dcarry_o,
	output logic            carry_o
);
	logic [8:0] full;
	logic [4:0] low;
	// subtract by ones complement plus one so carry is inverted borrow
	always_comb
	begin
		full = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
		low = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
		diff_o = full[7:0];
		zero_o = (full[7:0] == 8'h00);
		carry_o = full[8];
		dcarry_o = low[4];
	end
endmodule
`default_nettype wire

// file: hw/alu_table_timer_exec.sv
`default_nettype none
module alu_table_timer_exec
	import alu_ops_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             op_valid_i,
	input  wire logic [2:0]       op_code_i,
	input  wire logic [7:0]       op_imm_i,
	input  wire logic [5:0]       op_reg_i,
	input  wire logic             op_dest_i,
	output logic                  op_ready_o,
	output logic [10:0]           rom_addr_o,
	input  wire logic [13:0]      rom_data_i,
	output logic [7:0]            acc_o,
	output logic                  zero_flag_o,
	output logic                  digit_carry_flag_o,
	output logic                  carry_flag_o,
	output logic [7:0]            timer0_mode_reg_o,
	output logic [5:0]            table_data_high_o,
	output logic [7:0]            table_pointer_high_o,
	input  wire logic             reg_we_i,
	input  wire logic [5:0]       reg_waddr_i,
	input  wire logic [7:0]       reg_wdata_i,
	input  wire logic [5:0]       reg_raddr_i,
	output logic [7:0]            reg_rdata_o
);
	exec_state_e state_ff, nxt_state;
	logic [7:0] acc_ff, nxt_acc;
	logic       z_ff, nxt_z, dc_ff, nxt_dc, c_ff, nxt_c;
	logic [7:0] t0m_ff, nxt_t0m;
	logic [7:0] tph_ff, nxt_tph;
	logic [5:0] tdh_ff, nxt_tdh;
	logic [10:0] rom_addr_ff, nxt_rom_addr;
	logic [7:0] rd_ff, nxt_rd;
	logic [7:0] regs [0:(1 << REG_AW) - 1];
	logic       rf_we;
	logic [5:0] rf_wa;
	logic [7:0] rf_wd;
	logic [7:0] sub_res;
	logic       sub_z, sub_dc, sub_c;
	logic [7:0] xor_res;

	// zero test shared by both xor forms
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction

	sub_flags u_sub (
		.minuend_i    (op_imm_i),
		.subtrahend_i (acc_ff),
		.diff_o       (sub_res),
		.zero_o       (sub_z),
		.dcarry_o     (sub_dc),
		.carry_o      (sub_c)
	);

	assign xor_res = acc_ff ^ regs[op_reg_i];
	// table read stalls the stream for its second cycle
	assign op_ready_o = (state_ff == ST_EXEC);

	// instruction execution, next values
	always_comb
	begin
		nxt_state = state_ff;
		nxt_acc = acc_ff;
		nxt_z = z_ff;
		nxt_dc = dc_ff;
		nxt_c = c_ff;
		nxt_t0m = t0m_ff;
		nxt_tph = tph_ff;
		nxt_tdh = tdh_ff;
		nxt_rom_addr = rom_addr_ff;
		rf_we = reg_we_i;
		rf_wa = reg_waddr_i;
		rf_wd = reg_wdata_i;
		case (state_ff)
			ST_EXEC:
			begin
				if (op_valid_i)
				begin
					case (op_code_i)
						OP_SUB_IMM:
						begin
							nxt_acc = sub_res;
							nxt_z = sub_z;
							nxt_dc = sub_dc;
							nxt_c = sub_c;
						end
						OP_TABLE:
						begin
							nxt_rom_addr = {tph_ff[PTR_BITS-1:0], acc_ff};
							nxt_state = ST_TABLE;
						end
						OP_T0_LOAD: nxt_t0m = acc_ff;
						OP_T0_READ: nxt_acc = t0m_ff;
						OP_XOR_REG:
						begin
							nxt_z = is_zero(xor_res);
							if (op_dest_i)
							begin
								rf_we = 1'b1;
								rf_wa = op_reg_i;
								rf_wd = xor_res;
							end
							else
								nxt_acc = xor_res;
						end
						OP_XOR_IMM:
						begin
							nxt_acc = acc_ff ^ op_imm_i;
							nxt_z = is_zero(acc_ff ^ op_imm_i);
						end
						OP_TPH_LOAD: nxt_tph = acc_ff;
						default: ;
					endcase
				end
			end
			ST_TABLE:
			begin
				nxt_acc = rom_data_i[DATA_W-1:0];
				nxt_tdh = rom_data_i[ROM_W-1:DATA_W];
				nxt_state = ST_EXEC;
			end
			default: nxt_state = ST_EXEC;
		endcase
		nxt_rd = (rf_we && rf_wa == reg_raddr_i) ? rf_wd : regs[reg_raddr_i];
	end

	// state registers; data register file holds no reset
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_ff <= ST_EXEC;
			acc_ff <= ACC_RST;
			z_ff <= 1'b0;
			dc_ff <= 1'b0;
			c_ff <= 1'b0;
			t0m_ff <= T0MODE_RST;
			tph_ff <= TPH_RST;
			tdh_ff <= TDH_RST;
			rom_addr_ff <= '0;
			rd_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			acc_ff <= nxt_acc;
			z_ff <= nxt_z;
			dc_ff <= nxt_dc;
			c_ff <= nxt_c;
			t0m_ff <= nxt_t0m;
			tph_ff <= nxt_tph;
			tdh_ff <= nxt_tdh;
			rom_addr_ff <= nxt_rom_addr;
			rd_ff <= nxt_rd;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rf_we)
			regs[rf_wa] <= rf_wd;
	end

	assign rom_addr_o = rom_addr_ff;
	assign acc_o = acc_ff;
	assign zero_flag_o = z_ff;
	assign digit_carry_flag_o = dc_ff;
	assign carry_flag_o = c_ff;
	assign timer0_mode_reg_o = t0m_ff;
	assign table_data_high_o = tdh_ff;
	assign table_pointer_high_o = tph_ff;
	assign reg_rdata_o = rd_ff;

	a_sub_result: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_SUB_IMM) |=>
		acc_o == 8'($past(op_imm_i) - $past(acc_o)))
		else $error("subtract result wrong");
	a_sub_carry: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_SUB_IMM) |=>
		carry_flag_o == ($past(op_imm_i) >= $past(acc_o)))
		else $error("carry not inverted borrow");
	a_table_two: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_TABLE) |=>
		!op_ready_o ##1 op_ready_o)
		else $error("table read not two cycles");
	a_table_addr: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_TABLE) |=>
		rom_addr_o == {$past(table_pointer_high_o[2:0]), $past(acc_o)})
		else $error("table address wrong");
	a_table_high: assert property (@(posedge clk_i) disable iff (reset_i)
		(state_ff == ST_TABLE) |=>
		table_data_high_o == $past(rom_data_i[13:8])
		&& acc_o == $past(rom_data_i[7:0]))
		else $error("table data wrong");
	a_t0_load: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_T0_LOAD) |=>
		timer0_mode_reg_o == $past(acc_o) && $stable(carry_flag_o))
		else $error("timer mode load wrong");
	a_t0_read: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_T0_READ) |=>
		acc_o == $past(timer0_mode_reg_o) && $stable(zero_flag_o))
		else $error("timer mode readback wrong");
	a_xor_dest: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_XOR_REG && op_dest_i)
		|=> $stable(acc_o) && $stable(carry_flag_o))
		else $error("xor to register touched accumulator");
	a_xor_imm: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_XOR_IMM) |=>
		acc_o == ($past(acc_o) ^ $past(op_imm_i))
		&& zero_flag_o == (acc_o == 8'h00) && $stable(digit_carry_flag_o))
		else $error("xor immediate wrong");
	// xor into the accumulator may only move the zero flag
	a_xor_reg_zero: assert property (@(posedge clk_i) disable iff (reset_i)
		(op_ready_o && op_valid_i && op_code_i == OP_XOR_REG && !op_dest_i)
		|=> zero_flag_o == (acc_o == 8'h00) && $stable(carry_flag_o)
		&& $stable(digit_carry_flag_o))
		else $error("xor register flags wrong");
	// a request held through the busy cycle must not execute early
	a_busy_refuse: assert property (@(posedge clk_i) disable iff (reset_i)
		!op_ready_o |=> op_ready_o && $stable(timer0_mode_reg_o)
		&& $stable(table_pointer_high_o))
		else $error("busy cycle not one or request taken");
endmodule
`default_nettype wire

// file: bench/mcu_alu_table_timer_ops_bench.sv
`default_nettype none
module mcu_alu_table_timer_ops_bench
	import alu_ops_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, reset_i, op_valid_i, op_dest_i, op_ready_o, reg_we_i;
	logic [2:0]  op_code_i;
	logic [7:0]  op_imm_i, acc_o, timer0_mode_reg_o, table_pointer_high_o;
	logic [7:0]  reg_wdata_i, reg_rdata_o, acc_m, rd;
	logic [5:0]  op_reg_i, reg_waddr_i, reg_raddr_i, table_data_high_o;
	logic [10:0] rom_addr_o;
	logic [13:0] rom_data_i;
	logic        zero_flag_o, digit_carry_flag_o, carry_flag_o;
	int          failures, total_checks, cycles;
	// asynchronous rom: each word is a fixed pattern of its address
	assign rom_data_i = {rom_addr_o[10:5], rom_addr_o[7:0] ^ 8'h5a};
	alu_table_timer_exec DUT (.clk_i(clk_i), .reset_i(reset_i),
		.op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_imm_i(op_imm_i),
		.op_reg_i(op_reg_i), .op_dest_i(op_dest_i), .op_ready_o(op_ready_o),
		.rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i), .acc_o(acc_o),
		.zero_flag_o(zero_flag_o), .digit_carry_flag_o(digit_carry_flag_o),
		.carry_flag_o(carry_flag_o), .timer0_mode_reg_o(timer0_mode_reg_o),
		.table_data_high_o(table_data_high_o),
		.table_pointer_high_o(table_pointer_high_o), .reg_we_i(reg_we_i),
		.reg_waddr_i(reg_waddr_i), .reg_wdata_i(reg_wdata_i),
		.reg_raddr_i(reg_raddr_i), .reg_rdata_o(reg_rdata_o));
	task automatic chk(input string n, input logic [13:0] s,
		input logic [13:0] e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// one instruction, results checked just past the edge that takes it
	task automatic op(input logic [2:0] c, input logic [7:0] i,
		input logic [5:0] r, input logic d);
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_code_i <= c;
		op_imm_i <= i;
		op_reg_i <= r;
		op_dest_i <= d;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		#1;
	endtask
	// xor with the known accumulator lands any wanted value
	task automatic set_acc(input logic [7:0] a);
		op(OP_XOR_IMM, a ^ acc_m, 6'h00, 1'b0);
		acc_m = a;
	endtask
	task automatic wreg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_waddr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask
	task automatic rreg(input logic [5:0] a);
		@(posedge clk_i);
		reg_raddr_i <= a;
		@(posedge clk_i);
		#1;
		rd = reg_rdata_o;
	endtask
	task automatic sub_case(input logic [7:0] a, input logic [7:0] i);
		set_acc(a);
		op(OP_SUB_IMM, i, 6'h00, 1'b0);
		acc_m = i - a;
		chk("sub acc", acc_o, acc_m);
		chk("sub zero", zero_flag_o, acc_m == 8'h00);
		chk("sub carry", carry_flag_o, i >= a);
		chk("sub dc", digit_carry_flag_o, i[3:0] >= a[3:0]);
	endtask
	task automatic t_reset;
		chk("acc", acc_o, ACC_RST);
		chk("flags", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h0);
		chk("ready", op_ready_o, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_sub;
		sub_case(8'h06, 8'h05);
		sub_case(8'h05, 8'h06);
		sub_case(8'h5a, 8'h5a);
		sub_case(8'h01, 8'hf0);
		$display("test sub done");
	endtask
	task automatic t_xor;
		set_acc(8'hf0);
		op(OP_XOR_IMM, 8'ha5, 6'h00, 1'b0);
		chk("xori acc", acc_o, 8'h55);
		chk("xori zero", zero_flag_o, 1'b0);
		chk("xori carry", carry_flag_o, 1'b1);
		wreg(6'h3f, 8'ha5);
		wreg(6'h00, 8'h55);
		op(OP_XOR_REG, 8'h00, 6'h3f, 1'b1);
		chk("xorr acc kept", acc_o, 8'h55);
		rreg(6'h3f);
		chk("xorr reg", rd, 8'hf0);
		op(OP_XOR_REG, 8'h00, 6'h00, 1'b0);
		chk("xorr acc", acc_o, 8'h00);
		chk("xorr zero", zero_flag_o, 1'b1);
		chk("xorr dc", digit_carry_flag_o, 1'b0);
		acc_m = 8'h00;
		$display("test xor done");
	endtask
	task automatic t_timer;
		set_acc(8'haa);
		op(OP_T0_LOAD, 8'h00, 6'h00, 1'b0);
		chk("t0 load", timer0_mode_reg_o, 8'haa);
		chk("t0 flags", {zero_flag_o, carry_flag_o}, 2'h1);
		set_acc(8'h00);
		op(OP_T0_READ, 8'h00, 6'h00, 1'b0);
		chk("t0 read", acc_o, 8'haa);
		chk("t0 kept", timer0_mode_reg_o, 8'haa);
		chk("t0 zero", zero_flag_o, 1'b1);
		acc_m = 8'haa;
		$display("test timer done");
	endtask
	task automatic t_table;
		set_acc(8'hfa);
		op(OP_TPH_LOAD, 8'h00, 6'h00, 1'b0);
		chk("tph", table_pointer_high_o, 8'hfa);
		set_acc(8'h34);
		// table read, then an xor held through the busy cycle until taken
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_code_i <= OP_TABLE;
		@(posedge clk_i);
		op_code_i <= OP_XOR_IMM;
		op_imm_i <= 8'hff;
		#1;
		chk("rom addr", rom_addr_o, 11'h234);
		chk("busy", op_ready_o, 1'b0);
		@(posedge clk_i);
		#1;
		chk("tbl acc", acc_o, 8'h6e);
		chk("tbl high", table_data_high_o, 6'h11);
		chk("tbl flags", {zero_flag_o, carry_flag_o}, 2'h1);
		chk("ready", op_ready_o, 1'b1);
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		#1;
		chk("held xor", acc_o, 8'h91);
		chk("held xor zero", zero_flag_o, 1'b0);
		acc_m = 8'h91;
		$display("test table done");
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// hang guard, well past the 56 or so cycles the tests need
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			end_sim();
		end
	end
	initial
	begin
		{reset_i, op_valid_i, op_code_i, op_imm_i, op_reg_i} = 19'h40000;
		{op_dest_i, reg_we_i, reg_waddr_i, reg_wdata_i, reg_raddr_i} = 22'h0;
		{failures, total_checks, cycles, acc_m} = '0;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		t_reset();
		t_sub();
		t_xor();
		t_timer();
		t_table();
		end_sim();
	end
endmodule
`default_nettype wire
